// File: vectored_interrupt_controller.sv
// Eight-input vectored interrupt controller with daisy-chain support
`timescale 1ns/1ps
module vectored_interrupt_controller import vic_pkg::*; (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_ctl_data_select,
    input wire logic [7:0] i_db,
    input wire logic [NUM_IRQ-1:0] i_irq_inputs,
    input wire logic i_intr_ack_n,
    input wire logic i_response_in_progress_n,
    input wire logic i_chain_enable_in,
    output logic [7:0] o_db,
    output logic o_db_oe,
    output logic o_response_in_progress_n,
    output logic o_response_in_progress_n_oe,
    output logic o_pause_n,
    output logic o_pause_n_oe,
    output logic o_chain_enable_out,
    output logic o_group_irq_out,
    output logic o_group_irq_oe
);
    bus_pins_t bus_s;
    chain_pins_t chn_s;
    bus_pins_t bus_prev_ff;
    logic [NUM_IRQ-1:0] irq_prev_ff;
    logic ack_prev_ff;
    logic rip_prev_ff;

    logic [NUM_IRQ-1:0] pending_request_reg;
    logic [NUM_IRQ-1:0] mask_ff;
    logic [7:0] mode_ff;
    logic [7:0] cmd_ff;
    logic mmask_ff;
    data_sel_t sel_ff;
    logic [4:0] mem_ptr_ff;
    logic [7:0] resp_mem [NUM_IRQ*RESP_BYTES];
    logic [1:0] byte_count [NUM_IRQ];

    ack_state_t state_ff;
    logic [2:0] sel_idx_ff;
    logic [1:0] byte_idx_ff;
    logic rip_drive_ff;
    logic pause_drive_ff;

    logic found;
    logic [2:0] found_idx;
    logic [NUM_IRQ-1:0] active;
    logic [NUM_IRQ-1:0] edge_set;
    logic [NUM_IRQ-1:0] ack_clr;
    logic wr_done;
    logic rd_done;
    logic ack_fall;
    logic ack_rise;
    logic ack_ok;
    logic cmd_wr;
    logic data_wr;
    logic soft_reset;
    logic any_req;
    logic [7:0] status;
    logic [7:0] rd_data;

    vic_sync #(.W(12), .RST(BUS_RST)) u_sync_bus (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_d({i_cs_n, i_rd_n, i_wr_n, i_ctl_data_select, i_db}),
        .o_q(bus_s)
    );

    vic_sync #(.W(11), .RST(CHAIN_RST)) u_sync_chain (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_d({i_irq_inputs, i_intr_ack_n, i_response_in_progress_n,
              i_chain_enable_in}),
        .o_q(chn_s)
    );

    vic_prio u_prio (
        .i_req(pending_request_reg & ~mask_ff),
        .o_found(found),
        .o_idx(found_idx)
    );

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_prev_ff <= BUS_RST;
            irq_prev_ff <= CHAIN_RST.irq;
            ack_prev_ff <= 1'b1;
            rip_prev_ff <= 1'b1;
        end else begin
            bus_prev_ff <= bus_s;
            irq_prev_ff <= chn_s.irq;
            ack_prev_ff <= chn_s.ack_n;
            rip_prev_ff <= chn_s.rip_n;
        end
    end

    // Strobes act at their trailing edge so the data has settled
    assign wr_done = !bus_prev_ff.wr_n && bus_s.wr_n && !bus_s.cs_n;
    assign rd_done = !bus_prev_ff.rd_n && bus_s.rd_n && !bus_s.cs_n;
    assign cmd_wr = wr_done && bus_s.cd;
    assign data_wr = wr_done && !bus_s.cd;
    assign soft_reset = cmd_wr && bus_s.db == CMD_RESET;

    // Edge of programmed direction only; a held level never re-arms
    assign active = mode_ff[MODE_RISING] ? chn_s.irq : ~chn_s.irq;
    assign edge_set = active & ~(mode_ff[MODE_RISING] ? irq_prev_ff
                                                      : ~irq_prev_ff);

    assign ack_fall = ack_prev_ff && !chn_s.ack_n;
    assign ack_rise = !ack_prev_ff && chn_s.ack_n;
    // A busy peer or a low chain input locks out acknowledges
    assign ack_ok = ack_fall && chn_s.ei
                    && (state_ff == ST_RESP || chn_s.rip_n);
    // Clear only the input chosen in the select cycle
    assign ack_clr = (state_ff == ST_SELECT && found)
                     ? (8'h01 << found_idx) : 8'h00;
    assign any_req = |(pending_request_reg & ~mask_ff);

    assign status = {any_req, mmask_ff, mode_ff[MODE_RISING],
                     mode_ff[MODE_GROUP_IRQ_OUT_HIGH], found, found_idx};

    always_comb begin
        case (sel_ff)
            SEL_IRR: rd_data = pending_request_reg;
            SEL_MASK: rd_data = mask_ff;
            SEL_MODE: rd_data = mode_ff;
            SEL_MEM: rd_data = resp_mem[mem_ptr_ff];
            default: rd_data = 8'h00;
        endcase
    end

    // Hardware set wins over any clear in the same cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pending_request_reg <= '0;
        end else if (soft_reset) begin
            pending_request_reg <= edge_set;
        end else if (data_wr && sel_ff == SEL_IRR) begin
            pending_request_reg <= bus_s.db | edge_set;
        end else begin
            pending_request_reg <= (pending_request_reg & ~ack_clr)
                                   | edge_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_ff <= 8'h00;
            mask_ff <= MASK_RST;
            mode_ff <= MODE_RST;
            mmask_ff <= 1'b0;
            sel_ff <= SEL_IRR;
            mem_ptr_ff <= 5'h00;
        end else if (soft_reset) begin
            cmd_ff <= 8'h00;
            mask_ff <= MASK_RST;
            mode_ff <= MODE_RST;
            mmask_ff <= 1'b0;
            sel_ff <= SEL_IRR;
            mem_ptr_ff <= 5'h00;
        end else if (cmd_wr) begin
            cmd_ff <= bus_s.db;
            if (bus_s.db == CMD_MMASK_SET) begin
                mmask_ff <= 1'b1;
            end else if (bus_s.db == CMD_MMASK_CLR) begin
                mmask_ff <= 1'b0;
            end else if (bus_s.db == CMD_SEL_IRR) begin
                sel_ff <= SEL_IRR;
            end else if (bus_s.db == CMD_SEL_MASK) begin
                sel_ff <= SEL_MASK;
            end else if (bus_s.db == CMD_SEL_MODE) begin
                sel_ff <= SEL_MODE;
            end else if (bus_s.db[7:6] == CMD_SEL_MEM) begin
                sel_ff <= SEL_MEM;
                mem_ptr_ff <= {bus_s.db[2:0], 2'b00};
            end
        end else if (data_wr) begin
            case (sel_ff)
                SEL_MASK: mask_ff <= bus_s.db;
                SEL_MODE: mode_ff <= bus_s.db;
                SEL_MEM: mem_ptr_ff <= mem_ptr_ff + 5'h01;
                default: ;
            endcase
        end else if (rd_done && !bus_s.cd && sel_ff == SEL_MEM) begin
            mem_ptr_ff <= mem_ptr_ff + 5'h01;
        end
    end

    // No reset here: memory and counts survive reset
    always_ff @(posedge i_clk) begin
        if (data_wr && sel_ff == SEL_MEM) begin
            resp_mem[mem_ptr_ff] <= bus_s.db;
        end
        if (cmd_wr && bus_s.db[7:6] == CMD_SET_COUNT) begin
            byte_count[bus_s.db[2:0]] <= bus_s.db[4:3];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= ST_IDLE;
            sel_idx_ff <= 3'h0;
            byte_idx_ff <= 2'h0;
            rip_drive_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (ack_ok) begin
                        state_ff <= ST_SELECT;
                    end
                end
                ST_SELECT: begin
                    if (found) begin
                        state_ff <= ST_RESP;
                        sel_idx_ff <= found_idx;
                        byte_idx_ff <= 2'h0;
                        rip_drive_ff <= 1'b1;
                    end else begin
                        state_ff <= ST_PASS;
                    end
                end
                ST_RESP: begin
                    if (ack_ok) begin
                        byte_idx_ff <= byte_idx_ff + 2'h1;
                    end else if (ack_rise
                                 && byte_idx_ff == byte_count[sel_idx_ff]) begin
                        rip_drive_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_PASS: begin
                    // Wait until a peer finishes or nobody took the cycle
                    if ((ack_rise && chn_s.rip_n)
                        || (!rip_prev_ff && chn_s.rip_n)) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Pause only from an idle acknowledge, released by in-progress low
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pause_drive_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && ack_ok) begin
            pause_drive_ff <= 1'b1;
        end else if (!chn_s.rip_n || chn_s.ack_n) begin
            pause_drive_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_db <= 8'h00;
            o_db_oe <= 1'b0;
        end else if (state_ff == ST_RESP && !chn_s.ack_n) begin
            // Index steps on this same edge, so look one byte ahead
            o_db <= resp_mem[{sel_idx_ff,
                              byte_idx_ff + {1'b0, ack_ok}}];
            o_db_oe <= 1'b1;
        end else if (!bus_s.cs_n && !bus_s.rd_n) begin
            o_db <= bus_s.cd ? status : rd_data;
            o_db_oe <= 1'b1;
        end else begin
            o_db <= 8'h00;
            o_db_oe <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_response_in_progress_n <= 1'b1;
            o_response_in_progress_n_oe <= 1'b0;
            o_pause_n <= 1'b1;
            o_pause_n_oe <= 1'b0;
            o_chain_enable_out <= 1'b0;
            o_group_irq_out <= 1'b1;
            o_group_irq_oe <= 1'b0;
        end else begin
            o_response_in_progress_n <= !rip_drive_ff;
            o_response_in_progress_n_oe <= rip_drive_ff;
            o_pause_n <= !pause_drive_ff;
            o_pause_n_oe <= pause_drive_ff;
            // Low while selecting or answering, or under master mask
            o_chain_enable_out <= chn_s.ei && !mmask_ff
                && !(state_ff == ST_SELECT || state_ff == ST_RESP)
                && !(state_ff == ST_IDLE && ack_ok);
            if (mode_ff[MODE_GROUP_IRQ_OUT_HIGH]) begin
                o_group_irq_out <= any_req;
                o_group_irq_oe <= 1'b1;
            end else begin
                o_group_irq_out <= !any_req;
                o_group_irq_oe <= any_req;
            end
        end
    end
endmodule // vectored_interrupt_controller

// File: vic_pkg.sv
// Constants, types and command codes for the vectored interrupt controller
//
// Overview of operation
// - Register transfers only while chip select low
// - Acknowledge responses ignore chip select
// - Read strobe drives selected information onto bus
// - Write strobe captures bus into addressed location
// - Control select: write command, read status
// - Data select: access location chosen by command
// - Request inputs synchronised, edge polarity programmable
// - Active edge sets and holds pending bit
// - New request needs fresh edge after clear
// - Responder pulls in-progress low until done
// - Others ignore acknowledges while in-progress low
// - One response byte per acknowledge, 1-4
// - First acknowledge selects highest request, asserts in-progress
// - Pause low on first acknowledge until in-progress
// - Later acknowledges never assert pause
// - Chain out low while selecting or answering an acknowledge
// - Master mask holds chain out low
// - Chain in low ignores acknowledges
// - Group interrupt when unmasked request pending
// - Group interrupt polarity programmable, open drain low
// - Acknowledge clears the selected pending bit
// - Masked requests stay pending, no group interrupt
// - Reset clears registers, sets mask, keeps memory
// - Response memory holds four bytes per input
package vic_pkg;
    localparam int NUM_IRQ = 8;
    localparam int RESP_BYTES = 4;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam int MODE_GROUP_IRQ_OUT_HIGH = 0;
    localparam int MODE_RISING = 1;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMD_MMASK_SET = 8'h01;
    localparam logic [7:0] CMD_MMASK_CLR = 8'h02;
    localparam logic [7:0] CMD_SEL_IRR = 8'h10;
    localparam logic [7:0] CMD_SEL_MASK = 8'h11;
    localparam logic [7:0] CMD_SEL_MODE = 8'h12;
    localparam logic [1:0] CMD_SEL_MEM = 2'h2;
    localparam logic [1:0] CMD_SET_COUNT = 2'h3;

    typedef enum {SEL_IRR, SEL_MASK, SEL_MODE, SEL_MEM} data_sel_t;
    typedef enum {ST_IDLE, ST_SELECT, ST_RESP, ST_PASS} ack_state_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cd;
        logic [7:0] db;
    } bus_pins_t;

    typedef struct packed {
        logic [7:0] irq;
        logic ack_n;
        logic rip_n;
        logic ei;
    } chain_pins_t;

    localparam bus_pins_t BUS_RST = 12'hf00;
    localparam chain_pins_t CHAIN_RST = 11'h007;
endpackage

// File: vic_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module vic_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else begin
            s1_ff <= i_d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Bit changes only once the last two stages agree
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_q <= RST;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    o_q[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule // vic_sync

// File: vic_prio.sv
// Fixed priority selector over pending unmasked requests
`timescale 1ns/1ps
module vic_prio import vic_pkg::*; (
    input wire logic [NUM_IRQ-1:0] i_req,
    output logic o_found,
    output logic [2:0] o_idx
);
    always_comb begin
        o_found = 1'b0;
        o_idx = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_found = 1'b1;
                o_idx = 3'(i);
            end
        end
    end
endmodule // vic_prio

// File: vic_sva.sv
// Port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vic_sva (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_intr_ack_n,
    input wire logic i_response_in_progress_n,
    input wire logic i_chain_enable_in,
    input wire logic o_db_oe,
    input wire logic o_response_in_progress_n,
    input wire logic o_response_in_progress_n_oe,
    input wire logic o_pause_n,
    input wire logic o_pause_n_oe,
    input wire logic o_chain_enable_out,
    input wire logic o_group_irq_out,
    input wire logic o_group_irq_oe
);
    // Saturating counts; pins pass a synchroniser, so limits allow 8 cycles
    logic [3:0] quiet_ff, ei_lo_ff, ext_lo_ff, ack_hi_ff;
    function automatic logic [3:0] inc(input logic [3:0] c);
        return (c == 4'hf) ? c : c + 4'h1;
    endfunction
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            quiet_ff <= 4'hf;
            ei_lo_ff <= 4'h0;
            ext_lo_ff <= 4'h0;
            ack_hi_ff <= 4'h0;
        end else begin
            quiet_ff <= (!i_rd_n && !i_cs_n || !i_intr_ack_n) ? 4'h0
                : inc(quiet_ff);
            ei_lo_ff <= !i_chain_enable_in ? inc(ei_lo_ff) : 4'h0;
            ext_lo_ff <= (!i_response_in_progress_n
                && !o_response_in_progress_n_oe) ? inc(ext_lo_ff) : 4'h0;
            ack_hi_ff <= i_intr_ack_n ? inc(ack_hi_ff) : 4'h0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_own_rip;
        o_response_in_progress_n_oe && !i_response_in_progress_n;
    endsequence
    sequence s_rip_start;
        $rose(o_response_in_progress_n_oe);
    endsequence
    property p_pause_rel;
        s_own_rip [*8] |-> !o_pause_n_oe;
    endproperty
    property p_pause_od;
        o_pause_n_oe |-> !o_pause_n;
    endproperty
    property p_pause_later;
        o_response_in_progress_n_oe ##1 o_response_in_progress_n_oe
            |-> !$rose(o_pause_n_oe);
    endproperty
    property p_rip_db;
        s_rip_start |-> ##[0:2] o_db_oe;
    endproperty
    property p_chain;
        o_response_in_progress_n_oe |-> !o_chain_enable_out;
    endproperty
    property p_ei;
        s_rip_start |-> ei_lo_ff < 4'h8;
    endproperty
    property p_busy;
        s_rip_start |-> ext_lo_ff < 4'h8;
    endproperty
    property p_db_cause;
        $rose(o_db_oe) |-> quiet_ff < 4'h8;
    endproperty
    property p_rip_hold;
        $fell(o_response_in_progress_n_oe) |-> ack_hi_ff >= 4'h2;
    endproperty
    property p_rip_od;
        o_response_in_progress_n_oe |-> !o_response_in_progress_n;
    endproperty
    property p_group_irq_out_od;
        !o_group_irq_oe |-> o_group_irq_out;
    endproperty
    a_pause_rel: assert property (p_pause_rel)
        else $error("pause held after in-progress low");
    a_pause_od: assert property (p_pause_od)
        else $error("pause driven high");
    a_pause_later: assert property (p_pause_later)
        else $error("pause on later byte");
    a_rip_db: assert property (p_rip_db)
        else $error("no byte with in-progress");
    a_chain: assert property (p_chain)
        else $error("chain out high while responding");
    a_ei: assert property (p_ei)
        else $error("response while chain in low");
    a_busy: assert property (p_busy)
        else $error("response while line busy");
    a_db_cause: assert property (p_db_cause)
        else $error("bus driven without cause");
    a_rip_hold: assert property (p_rip_hold)
        else $error("in-progress dropped during acknowledge");
    a_rip_od: assert property (p_rip_od)
        else $error("in-progress driven high");
    a_group_irq_out_od: assert property (p_group_irq_out_od)
        else $error("group irq not released high");
endmodule // vic_sva

// File: vic_peer.sv
// Wired lines of the host side and a peer controller on in-progress
`timescale 1ns/1ps
module vic_peer (
    input wire logic i_peer_rip_n,
    input wire logic i_rip_oe,
    input wire logic i_pause_oe,
    input wire logic i_group_irq_out,
    input wire logic i_group_irq_out_oe,
    output logic o_rip_wire,
    output logic o_pause_wire,
    output logic o_group_irq_out_wire
);
    // Pull-ups give the level whenever no party pulls low
    assign o_rip_wire = !(i_rip_oe || !i_peer_rip_n);
    assign o_pause_wire = !i_pause_oe;
    assign o_group_irq_out_wire = i_group_irq_out_oe ? i_group_irq_out : 1'b1;
endmodule // vic_peer

// File: tb_vectored_interrupt_controller.sv
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_vectored_interrupt_controller import vic_pkg::*;;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    bus_pins_t bus = BUS_RST;
    chain_pins_t ch = CHAIN_RST;
    logic [7:0] dbo, m_pend, m_mask, m_mode, v;
    logic db_oe, rip_oe, pause_n, pause_oe, eo, group_irq_out, group_irq_out_oe;
    logic rip_w, pause_w, group_irq_out_w, m_mm;
    logic [7:0] mem [32];
    int cnt [8];
    int err_total = 0;
    int checks = 0;
    initial forever #50 i_clk = ~i_clk;
    vectored_interrupt_controller DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_cs_n(bus.cs_n), .i_rd_n(bus.rd_n), .i_wr_n(bus.wr_n),
        .i_ctl_data_select(bus.cd), .i_db(bus.db), .i_irq_inputs(ch.irq),
        .i_intr_ack_n(ch.ack_n), .i_response_in_progress_n(rip_w),
        .i_chain_enable_in(ch.ei), .o_db(dbo), .o_db_oe(db_oe),
        .o_response_in_progress_n(),
        .o_response_in_progress_n_oe(rip_oe), .o_pause_n(pause_n),
        .o_pause_n_oe(pause_oe), .o_chain_enable_out(eo),
        .o_group_irq_out(group_irq_out), .o_group_irq_oe(group_irq_out_oe));
    vic_peer u_peer (.i_peer_rip_n(ch.rip_n), .i_rip_oe(rip_oe),
        .i_pause_oe(pause_oe), .i_group_irq_out(group_irq_out), .i_group_irq_out_oe(group_irq_out_oe),
        .o_rip_wire(rip_w), .o_pause_wire(pause_w), .o_group_irq_out_wire(group_irq_out_w));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    // Which 0 waits for the bus drive, 1 for the pause release
    task automatic wait_for(input bit which);
        int k;
        k = 0;
        while ((which ? pause_w : db_oe) !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        if ((which ? pause_w : db_oe) !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // Release of a strobe is held off until the other pins have settled
    task automatic wr(input logic cd, input logic [7:0] d, input logic cs);
        bus.cd = cd;
        bus.db = d;
        bus.cs_n = cs;
        bus.wr_n = 1'b0;
        tick(6);
        bus.wr_n = 1'b1;
        tick(6);
        bus.cs_n = 1'b1;
        bus.db = ~d;
        tick(6);
    endtask
    task automatic rd(input logic cd, input logic [7:0] e, input string nm);
        bus.cd = cd;
        bus.cs_n = 1'b0;
        bus.rd_n = 1'b0;
        wait_for(1'b0);
        tick(1);
        chk(nm, e, dbo);
        bus.rd_n = 1'b1;
        tick(6);
        bus.cs_n = 1'b1;
        tick(6);
    endtask
    task automatic ack(input logic resp, input logic [7:0] e, input string nm);
        ch.ack_n = 1'b0;
        if (resp) begin
            wait_for(1'b0);
            wait_for(1'b1);
            tick(1);
            chk(nm, e, dbo);
        end else begin
            tick(12);
            chk(nm, 8'h00, {7'h0, db_oe});
        end
        ch.ack_n = 1'b1;
        tick(8);
    endtask
    function automatic int top(input logic [7:0] u);
        top = 8;
        for (int i = 7; i >= 0; i--)
            if (u[i]) top = i;
    endfunction
    function automatic logic [7:0] stat();
        logic [7:0] u;
        u = m_pend & ~m_mask;
        return {|u, m_mm, m_mode[1], m_mode[0], |u, 3'(top(u))};
    endfunction
    task automatic gchk();
        logic a;
        a = |(m_pend & ~m_mask);
        chk("group_irq_out", {7'h0, m_mode[0] ? a : !a}, {7'h0, group_irq_out_w});
    endtask
    task automatic serve();
        int i;
        while (|(m_pend & ~m_mask)) begin
            i = top(m_pend & ~m_mask);
            for (int n = 0; n < cnt[i]; n++) begin
                ack(1'b1, mem[i*4+n], "resp");
                chk("rip", {7'h0, n == cnt[i] - 1}, {7'h0, rip_w});
            end
            m_pend[i] = 1'b0;
        end
        gchk();
        wr(1'b1, CMD_SEL_IRR, 1'b0);
        rd(1'b0, m_pend, "pending");
    endtask
    task automatic setreg(input logic [7:0] c, d);
        wr(1'b1, c, 1'b0);
        wr(1'b0, d, 1'b0);
    endtask
    initial begin
        v = $urandom(32'hac2889df);
        tick(5);
        i_arst_n = 1'b1;
        tick(6);
        {m_pend, m_mask, m_mode, m_mm} = {8'h00, MASK_RST, MODE_RST, 1'b0};
        rd(1'b1, stat(), "status");
        wr(1'b1, CMD_SEL_MASK, 1'b0);
        rd(1'b0, MASK_RST, "mask");
        for (int i = 0; i < 8; i++) begin
            wr(1'b1, {CMD_SEL_MEM, 3'h0, 3'(i)}, 1'b0);
            for (int n = 0; n < 4; n++) begin
                mem[i*4+n] = 8'($urandom);
                wr(1'b0, mem[i*4+n], 1'b0);
            end
            cnt[i] = $urandom_range(1, 4);
            wr(1'b1, {CMD_SET_COUNT, 1'b0, 2'(cnt[i] - 1), 3'(i)}, 1'b0);
        end
        m_mode = 8'h02;
        setreg(CMD_SEL_MODE, m_mode);
        rd(1'b0, m_mode, "mode");
        m_mask = 8'h00;
        setreg(CMD_SEL_MASK, m_mask);
        wr(1'b0, 8'hff, 1'b1);
        rd(1'b0, 8'h00, "mask cs");
        v = 8'($urandom) | 8'h81;
        ch.irq = v;
        m_pend = v;
        tick(10);
        gchk();
        rd(1'b1, stat(), "status");
        serve();
        m_mask = 8'h01;
        setreg(CMD_SEL_MASK, m_mask);
        ch.irq[0] = 1'b0;
        tick(8);
        ch.irq[0] = 1'b1;
        m_pend[0] = 1'b1;
        tick(10);
        gchk();
        ack(1'b0, 8'h00, "no request");
        chk("eo pass", 8'h01, {7'h0, eo});
        rd(1'b1, stat(), "masked status");
        wr(1'b1, CMD_MMASK_SET, 1'b0);
        m_mm = 1'b1;
        chk("eo mmask", 8'h00, {7'h0, eo});
        rd(1'b1, stat(), "mmask status");
        wr(1'b1, CMD_MMASK_CLR, 1'b0);
        m_mm = 1'b0;
        m_mask = 8'h00;
        setreg(CMD_SEL_MASK, m_mask);
        ch.ei = 1'b0;
        tick(8);
        ack(1'b0, 8'h00, "ei low");
        ch.ei = 1'b1;
        ch.rip_n = 1'b0;
        tick(8);
        ack(1'b0, 8'h00, "line busy");
        ch.rip_n = 1'b1;
        tick(8);
        serve();
        ch.irq = 8'hff;
        tick(10);
        wr(1'b1, CMD_RESET, 1'b0);
        {m_pend, m_mask, m_mode} = {8'h00, MASK_RST, MODE_RST};
        wr(1'b1, CMD_SEL_MASK, 1'b0);
        rd(1'b0, MASK_RST, "mask soft");
        m_mask = 8'h00;
        wr(1'b0, m_mask, 1'b0);
        v = 8'($urandom) | 8'h10;
        ch.irq = ~v;
        m_pend = v;
        tick(10);
        gchk();
        serve();
        m_mode = 8'h01;
        setreg(CMD_SEL_MODE, m_mode);
        ch.irq = 8'hff;
        tick(8);
        ch.irq = 8'h7f;
        m_pend = 8'h80;
        tick(10);
        gchk();
        serve();
        wr(1'b1, {CMD_SEL_MEM, 3'h0, 3'h2}, 1'b0);
        rd(1'b0, mem[8], "mem read");
        rd(1'b0, mem[9], "mem next");
        m_pend = 8'h24;
        wr(1'b1, CMD_SEL_IRR, 1'b0);
        wr(1'b0, m_pend, 1'b0);
        gchk();
        serve();
        report_and_stop();
    end
endmodule // tb_vectored_interrupt_controller
bind vectored_interrupt_controller vic_sva u_sva (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
    .i_intr_ack_n(i_intr_ack_n),
    .i_response_in_progress_n(i_response_in_progress_n),
    .i_chain_enable_in(i_chain_enable_in), .o_db_oe(o_db_oe),
    .o_response_in_progress_n(o_response_in_progress_n),
    .o_response_in_progress_n_oe(o_response_in_progress_n_oe),
    .o_pause_n(o_pause_n), .o_pause_n_oe(o_pause_n_oe),
    .o_chain_enable_out(o_chain_enable_out),
    .o_group_irq_out(o_group_irq_out), .o_group_irq_oe(o_group_irq_oe));
